// >>> design/ris_defines.svh
`ifndef RIS_DEFINES_SVH
`define RIS_DEFINES_SVH
// Purpose : Constants for the reset initialization sequencer
// Assumes : Core clock of 200 MHz
// Notes   : Times kept in their own unit, cycle counts derived
`define RIS_CLK_MHZ        200
`define RIS_PLL_LOCK_US    100
`define RIS_PLL_LOCK_CYC   (`RIS_PLL_LOCK_US * `RIS_CLK_MHZ)
`define RIS_HIN_TICKS      6'd32
`define RIS_HOUT_TICKS     10'd512
`define RIS_RESUME_TICKS   2'd2
`define RIS_STRAP_W        5
`define RIS_SRC_W          4
`define RIS_NPLL           4
// Synchronised input vector layout
`define RIS_IN_POR         0
`define RIS_IN_HRST        1
`define RIS_IN_PCLK        2
`define RIS_IN_SCLK        3
`define RIS_IN_HOST        4
`define RIS_IN_STRAP       5
`define RIS_IN_LOCK        10
`define RIS_IN_W           14
`define RIS_CFG_RST        5'h00
`endif

// >>> design/ris_pkg.sv
// Purpose : Types for the reset initialization sequencer
// Assumes : ris_defines.svh included first
// Notes   : One-hot state codes written out
package ris_pkg;
  typedef struct packed {
    logic [3:0] reset_source;
    logic       clock_divider_strap;
  } ris_cfg_t;

  typedef enum logic [6:0] {
    RIS_ST_POR    = 7'h01,
    RIS_ST_PLL    = 7'h02,
    RIS_ST_HOUT   = 7'h04,
    RIS_ST_WREL   = 7'h08,
    RIS_ST_RESUME = 7'h10,
    RIS_ST_RUN    = 7'h20,
    RIS_ST_HIN    = 7'h40
  } ris_state_t;
endpackage

// >>> design/ris_reset_init_sequencer.sv
`include "ris_defines.svh"
// Purpose : Reset initialization flow: POR strap latch, PLL wait, hard reset drive
// Assumes : All pin inputs asynchronous to core_clk_i; clocks sampled as levels
// Notes   : Strap release follows an external hard reset assertion with synchroniser latency
//
// Functional notes
// - Count primary clock in host mode, sync clock in agent mode.
// - Device drives hard reset low for at least 512 sync periods.
// - Device releases strap pins as soon as it asserts hard reset; on an external assertion, after synchroniser latency.
// - Strap drive resumes at least one sync period after hard reset negates.
// - Configuration is four reset-source bits plus one divider strap.
// - Host mode derives sync period from primary clock and divider strap.
// - Allow up to 100 us for lock of each of four PLLs.
module ris_reset_init_sequencer
  import ris_pkg::*;
#(
  parameter int PLL_LOCK_CYC = `RIS_PLL_LOCK_CYC
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    power_on_reset_n_i,
  input  wire logic                    hard_reset_n_i,
  output logic                         hard_reset_n_o,
  output logic                         hard_reset_oe_o,
  input  wire logic                    primary_clock_in_i,
  input  wire logic                    bus_sync_clk_i,
  input  wire logic                    host_mode_i,
  input  wire logic [`RIS_STRAP_W-1:0] strap_i,
  output logic      [`RIS_STRAP_W-1:0] strap_o,
  output logic                         strap_oe_o,
  input  wire logic [`RIS_NPLL-1:0]    pll_lock_i,
  output logic                         pll_timeout_o,
  output logic                         ready_o
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [`RIS_IN_W-1:0] raw;
  logic [`RIS_IN_W-1:0] s1;
  logic [`RIS_IN_W-1:0] s2;
  logic [`RIS_IN_W-1:0] s3;
  logic [`RIS_IN_W-1:0] filt;

  assign raw = {pll_lock_i, strap_i, host_mode_i, bus_sync_clk_i,
                primary_clock_in_i, hard_reset_n_i, power_on_reset_n_i};

  // Three stages; a change counts once stages two and three agree
  generate
    for (genvar gi = 0; gi < `RIS_IN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
          s1[gi]   <= 1'b0;
          s2[gi]   <= 1'b0;
          s3[gi]   <= 1'b0;
          filt[gi] <= 1'b0;
        end else begin
          s1[gi] <= raw[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi]) begin
            filt[gi] <= s3[gi];
          end
        end
      end
    end
  endgenerate

  logic                    por_f;
  logic                    hrst_f;
  logic                    host_f;
  logic [`RIS_STRAP_W-1:0] strap_f;
  logic [`RIS_NPLL-1:0]    lock_f;
  assign por_f   = filt[`RIS_IN_POR];
  assign hrst_f  = filt[`RIS_IN_HRST];
  assign host_f  = filt[`RIS_IN_HOST];
  assign strap_f = filt[`RIS_IN_STRAP +: `RIS_STRAP_W];
  assign lock_f  = filt[`RIS_IN_LOCK +: `RIS_NPLL];

  // ==========================================================
  // Sync clock tick: derived in host mode, sampled in agent mode
  // ==========================================================
  logic     pclk_d;
  logic     sclk_d;
  logic     div_ph;
  logic     next_div_ph;
  logic     prim_rise;
  logic     sclk_rise;
  logic     sync_tick;
  ris_cfg_t cfg;

  assign prim_rise = filt[`RIS_IN_PCLK] & ~pclk_d;
  assign sclk_rise = filt[`RIS_IN_SCLK] & ~sclk_d;

  // Divider strap 0 passes every primary edge, 1 every second
  always_comb begin
    next_div_ph = div_ph;
    if (prim_rise) begin
      next_div_ph = cfg.clock_divider_strap ? ~div_ph : 1'b0;
    end
  end

  assign sync_tick = host_f ? (prim_rise & (~cfg.clock_divider_strap | div_ph))
                            : sclk_rise;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pclk_d <= 1'b0;
      sclk_d <= 1'b0;
      div_ph <= 1'b0;
    end else begin
      pclk_d <= filt[`RIS_IN_PCLK];
      sclk_d <= filt[`RIS_IN_SCLK];
      div_ph <= next_div_ph;
    end
  end
  // ==========================================================
  // Reset flow state machine
  // ==========================================================
  ris_state_t state;
  ris_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  ris_cfg_t    next_cfg;
  logic        hoe;
  logic        next_hoe;
  logic        soe;
  logic        next_soe;
  logic        tmo;
  logic        next_tmo;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cfg   = cfg;
    next_hoe   = hoe;
    next_soe   = soe;
    next_tmo   = tmo;
    if (!por_f) begin
      // Power-on reset overrides every state; pins released
      next_state = RIS_ST_POR;
      next_cnt   = 16'h0000;
      next_hoe   = 1'b0;
      next_soe   = 1'b0;
    end else begin
      case (state)
        RIS_ST_POR: begin
          next_cfg   = ris_cfg_t'(strap_f);
          next_state = RIS_ST_PLL;
          next_cnt   = 16'h0000;
        end
        RIS_ST_PLL: begin
          // Proceed on full lock or when the lock budget runs out
          if ((&lock_f) || (cnt == 16'(PLL_LOCK_CYC - 1))) begin
            next_tmo   = ~(&lock_f);
            next_state = RIS_ST_HOUT;
            next_hoe   = 1'b1;
            next_soe   = 1'b0;
            next_cnt   = 16'h0000;
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
        RIS_ST_HOUT: begin
          if (sync_tick) begin
            if (cnt == 16'(`RIS_HOUT_TICKS)) begin // extra edge: full periods from any phase
              next_hoe   = 1'b0;
              next_state = RIS_ST_WREL;
              next_cnt   = 16'h0000;
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end
        end
        RIS_ST_WREL: begin
          // Board may still hold the wire low after we let go
          if (hrst_f) begin
            next_state = RIS_ST_RESUME;
            next_cnt   = 16'h0000;
          end
        end
        RIS_ST_RESUME: begin
          // Two ticks guarantee one full sync period after negation
          if (!hrst_f) begin
            next_state = RIS_ST_HIN;
            next_cnt   = 16'h0000;
          end else if (sync_tick) begin
            if (cnt == 16'(`RIS_RESUME_TICKS - 2'd1)) begin
              next_soe   = 1'b1;
              next_state = RIS_ST_RUN;
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end
        end
        RIS_ST_RUN: begin
          if (!hrst_f) begin
            next_soe   = 1'b0;
            next_state = RIS_ST_HIN;
            next_cnt   = 16'h0000;
          end
        end
        RIS_ST_HIN: begin
          // Short pulses are ignored; a held assertion restarts the flow
          if (hrst_f) begin
            next_state = RIS_ST_RESUME;
            next_cnt   = 16'h0000;
          end else if (sync_tick) begin
            if (cnt == 16'(`RIS_HIN_TICKS - 6'd1)) begin
              next_state = RIS_ST_PLL;
              next_cnt   = 16'h0000;
            end else begin
              next_cnt = cnt + 16'h0001;
            end
          end
        end
        default: begin
          next_state = RIS_ST_POR;
          next_cnt   = 16'h0000;
          next_hoe   = 1'b0;
          next_soe   = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= RIS_ST_POR;
      cnt   <= 16'h0000;
      cfg   <= ris_cfg_t'(`RIS_CFG_RST);
      hoe   <= 1'b0;
      soe   <= 1'b0;
      tmo   <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      cfg   <= next_cfg;
      hoe   <= next_hoe;
      soe   <= next_soe;
      tmo   <= next_tmo;
    end
  end
  // Outputs straight from state flops; the pin is only ever pulled low
  assign hard_reset_n_o  = 1'b0;
  assign hard_reset_oe_o = hoe;
  assign strap_o         = cfg;
  assign strap_oe_o      = soe;
  assign pll_timeout_o   = tmo;
  assign ready_o         = state[5];

  // ==========================================================
  // Assertions
  // ==========================================================
  logic [15:0] hout_ticks;
  logic [1:0]  rel_ticks;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !hoe) begin
      hout_ticks <= 16'h0000;
    end else if (sync_tick) begin
      hout_ticks <= hout_ticks + 16'h0001;
    end
    if (srst_i || !hrst_f) begin
      rel_ticks <= 2'd0;
    end else if (sync_tick && rel_ticks != 2'd3) begin
      rel_ticks <= rel_ticks + 2'd1;
    end
  end

  a_agent_tick_src: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !host_f |-> (sync_tick == sclk_rise))
    else $error("agent mode tick not from sync clock");
  a_hout_width: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(hoe) && por_f |-> $past(hout_ticks) >= 16'd512)
    else $error("hard reset output pulse too short");
  a_strap_release: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(hoe) |-> !soe)
    else $error("straps driven while hard reset asserted");
  a_strap_resume: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(soe) |-> hrst_f && $past(rel_ticks) >= 2'd1)
    else $error("strap drive resumed too early");
  a_strap_value: assert property (@(posedge core_clk_i) disable iff (srst_i)
    soe |-> strap_o == cfg && !hoe)
    else $error("strap drive value wrong");
  a_host_div1: assert property (@(posedge core_clk_i) disable iff (srst_i)
    host_f && !cfg.clock_divider_strap |-> (sync_tick == prim_rise))
    else $error("host mode divide-by-one tick wrong");
  a_pll_budget: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state == RIS_ST_PLL && por_f && cnt == 16'(PLL_LOCK_CYC - 1) |=> state == RIS_ST_HOUT && hoe)
    else $error("PLL wait overran its budget");
  a_cfg_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state != RIS_ST_POR && $past(state) != RIS_ST_POR |-> $stable(cfg))
    else $error("latched configuration changed");
endmodule // ris_reset_init_sequencer

// >>> verif/ris_board_model.sv
// Purpose : Board reset controller and strap resistors around the sequencer
// Assumes : Reset wire has a pull-up; strap resistors always present
// Notes   : Clocks run free, as oscillators on a board do
module ris_board_model (
  input  wire logic       por_req_i,
  input  wire logic       hrst_req_i,
  input  wire logic [4:0] strap_val_i,
  input  wire logic       dev_hrst_n_i,
  input  wire logic       dev_hrst_oe_i,
  input  wire logic [4:0] dev_strap_i,
  input  wire logic       dev_strap_oe_i,
  output logic            por_n_o,
  output logic            hrst_wire_o,
  output logic [4:0]      strap_wire_o,
  output logic            pclk_o,
  output logic            sclk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Clocks: 25 MHz primary, 33 MHz sync
  initial pclk_o = 1'b0;
  initial sclk_o = 1'b0;
  always #20 pclk_o = ~pclk_o;
  always #15 sclk_o = ~sclk_o;
  // Wire levels: open drain pulled up, straps yield to the device
  assign por_n_o      = ~por_req_i;
  assign hrst_wire_o  = ~((dev_hrst_oe_i & ~dev_hrst_n_i) | hrst_req_i);
  assign strap_wire_o = dev_strap_oe_i ? dev_strap_i : strap_val_i;
endmodule // ris_board_model

// >>> verif/tb.sv
// Purpose : Self-checking bench for the reset sequencer
// Assumes : Board model supplies clocks and wire levels
// Notes   : Lock budget shortened to 50 cycles
`include "ris_defines.svh"
module tb
  import ris_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK = 50;
  logic core_clk_i = 1'b0, srst_i = 1'b1, host = 1'b0, por_req = 1'b1, hrst_req = 1'b0;
  logic [3:0] lock = 4'h0;
  ris_cfg_t cfg = 5'h00;
  logic por_n, hrst_w, pclk, sclk, hrn, hoe, soe, pto, ready_o;
  logic [4:0] sw, so;
  int bad_count = 0, tests_run = 0, cyc = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  ris_board_model u_ris_board_model (.por_req_i(por_req), .hrst_req_i(hrst_req),
    .strap_val_i(cfg), .dev_hrst_n_i(hrn), .dev_hrst_oe_i(hoe), .dev_strap_i(so),
    .dev_strap_oe_i(soe), .por_n_o(por_n), .hrst_wire_o(hrst_w), .strap_wire_o(sw),
    .pclk_o(pclk), .sclk_o(sclk));
  ris_reset_init_sequencer #(.PLL_LOCK_CYC(LOCK)) u_ris_reset_init_sequencer (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .power_on_reset_n_i(por_n),
    .hard_reset_n_i(hrst_w), .hard_reset_n_o(hrn), .hard_reset_oe_o(hoe),
    .primary_clock_in_i(pclk), .bus_sync_clk_i(sclk), .host_mode_i(host),
    .strap_i(sw), .strap_o(so), .strap_oe_o(soe), .pll_lock_i(lock),
    .pll_timeout_o(pto), .ready_o(ready_o));
  // ==========================================
  // Checking helpers
  task automatic end_of_test();
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int s);
    pick = (s == 0) ? hoe : (s == 1) ? soe : hrst_w;
  endfunction
  // Bounded wait on a design output or the reset wire, judged as a comparison
  task automatic wait_on(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(pick(s), v);
  endtask
  // Hang guard well above the longest flow
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========================================
  // Power-on reset with straps set up front
  task automatic run_por(input logic h, input ris_cfg_t c, output int n);
    @(negedge core_clk_i);
    host = h;
    cfg = c;
    por_req = 1'b1;
    repeat (300) @(negedge core_clk_i);
    por_req = 1'b0;
    wait_on(0, 1'b1, LOCK + 100, n);
  endtask
  // Whole hard reset output phase and strap resume
  task automatic flow(input real tick);
    realtime t0;
    int n;
    @(negedge core_clk_i);
    chk(soe, 1'b0);
    chk(so, cfg);
    t0 = $realtime;
    wait_on(0, 1'b0, 20000, n);
    chk($realtime - t0 >= 512.0 * tick, 1'b1);
    chk($realtime - t0 < 514.0 * tick, 1'b1);
    wait_on(2, 1'b1, 20, n);
    t0 = $realtime;
    wait_on(1, 1'b1, 200, n);
    chk($realtime - t0 >= tick, 1'b1);
    chk(ready_o, 1'b1);
    chk(sw, cfg);
  endtask
  task automatic t_agent();
    int n;
    lock = 4'hF;
    run_por(1'b0, 5'h1B, n);
    chk(pto, 1'b0);
    flow(30.0);
  endtask
  task automatic t_host();
    int n;
    run_por(1'b1, 5'h05, n);
    flow(80.0);
    run_por(1'b1, 5'h0A, n);
    flow(40.0);
  endtask
  task automatic t_timeout();
    int n;
    lock = 4'h7;
    run_por(1'b0, 5'h12, n);
    chk(n >= LOCK, 1'b1);
    chk(pto, 1'b1);
    flow(30.0);
  endtask
  // Short external pulse is refused, long one restarts the flow
  task automatic t_ext();
    int n;
    hrst_req = 1'b1;
    repeat (48) @(negedge core_clk_i);
    hrst_req = 1'b0;
    repeat (30) @(negedge core_clk_i);
    chk(hoe, 1'b0);
    wait_on(1, 1'b1, 200, n);
    hrst_req = 1'b1;
    wait_on(1, 1'b0, 10, n);
    wait_on(0, 1'b1, 300, n);
    chk(n >= 180, 1'b1);
    hrst_req = 1'b0;
    flow(30.0);
  endtask
  initial begin
    repeat (20) @(negedge core_clk_i);
    srst_i = 1'b0;
    chk({hoe, soe, ready_o, pto}, 4'h0);
    t_agent();
    t_ext();
    t_host();
    t_timeout();
    end_of_test();
  end
endmodule // tb
